// [hw/uwp_wake_ctrl.sv]
// usb wake detection, soft reset, phy control and axi4-lite register slave
//
// Overview of operation
// - writing one to soft reset trigger resets the whole usb controller logic
// - with wake enable set, k-state resume on bus sets wake seen status
// - enabled resume detection raises an interrupt without needing the usb clock
// - a resume wakeup event turns the usb controller clocks back on
// - combined flag set while any interrupt status bit and its enable are set
// - wake seen status sets once the processor is woken by resume signalling
// - clearing the wake enable bit clears the wake seen status
// - sie clock select at zero picks the 48 mhz decode clock
// - sie clock select at one picks the 60 mhz decode clock
// - reserved bit writes are ignored except in phy control 3, which stores all eight bits, and the access answers okay
`include "uwp_consts.svh"
`default_nettype none
module uwp_wake_ctrl (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    // axi4-lite write
    input wire logic [11:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    // axi4-lite read
    input wire logic [11:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    // usb line state, controller side
    input wire logic I_LINE_K,
    input wire logic I_STOP_MODE,
    input wire logic [7:0] I_USB_INT_STAT,
    input wire logic [7:0] I_USB_INTERRUPT_ENABLE_BITS,
    // controls out
    output logic O_USB_SOFT_RST,
    output logic O_USB_CLK_EN,
    output logic O_PHY_CLK_GATE,
    output logic O_SIE_CLK_SEL_60,
    output logic [4:0] O_PHY_CTRL,
    output logic O_WAKE_IRQ,
    output logic O_IRQ
);
    ////////////////////////////////////////////////////////////////////////////
    logic rst_s1, rst_n;
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                old[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return old;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // write channel state
    logic aw_held, w_held, bvalid, wake_en, clk_gate, usb_clk_en, wake_seen, wake_irq;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [7:0] phy3;
    logic [`UWP_IRQ_BITS-1:0] irq_stat, irq_mask;
    logic [3:0] srst_cnt;
    logic next_aw_held, next_w_held, next_bvalid, next_wake_en, next_clk_gate, next_usb_clk_en;
    logic next_wake_seen, next_wake_irq;
    logic [11:0] next_aw_addr;
    logic [31:0] next_w_data, merged;
    logic [3:0] next_w_strb, next_srst_cnt;
    logic [7:0] next_phy3;
    logic [`UWP_IRQ_BITS-1:0] next_irq_stat, next_irq_mask, ev;
    logic do_wr, resume_hit, combined;

    // combined flag
    // status and enable summary
    assign combined = |(I_USB_INT_STAT & I_USB_INTERRUPT_ENABLE_BITS);
    assign resume_hit = wake_en && I_LINE_K && !wake_seen;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_wake_en = wake_en;
        next_clk_gate = clk_gate;
        next_phy3 = phy3;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        next_usb_clk_en = usb_clk_en;
        next_wake_seen = wake_seen;
        next_wake_irq = wake_irq;
        next_srst_cnt = (srst_cnt != 4'h0) ? srst_cnt - 4'h1 : 4'h0;
        ev = '0;
        merged = 32'h0;
        if (I_AWVALID && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = I_AWADDR;
        end
        if (I_WVALID && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = I_WDATA;
            next_w_strb = I_WSTRB;
        end
        do_wr = aw_held && w_held && !bvalid;
        if (do_wr) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            unique case ({aw_addr[11:2], 2'b00})
                `UWP_OFS_WAKE_CTRL: begin
                    merged = lane_merge({24'h0, 2'b00, wake_en, clk_gate, 4'h0}, w_data, w_strb);
                    next_wake_en = merged[`UWP_BIT_WAKE_EN];
                    next_clk_gate = merged[`UWP_BIT_PHY_CLK_GATE];
                    if (w_strb[0] && w_data[`UWP_BIT_SOFT_RESET]) begin
                        next_srst_cnt = `UWP_SOFT_RESET_CYCLES;
                        ev[`UWP_IRQ_SOFT_RESET] = 1'b1;
                    end
                end
                `UWP_OFS_PHY_CTRL3: begin
                    merged = lane_merge({24'h0, phy3}, w_data, w_strb);
                    next_phy3 = merged[7:0] & `UWP_PHY3_MASK;
                end
                `UWP_OFS_IRQ_STAT: begin
                    if (w_strb[0]) begin
                        next_irq_stat = irq_stat & ~w_data[`UWP_IRQ_BITS-1:0];
                    end
                end
                `UWP_OFS_IRQ_MASK: begin
                    if (w_strb[0]) begin
                        next_irq_mask = w_data[`UWP_IRQ_BITS-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        if (bvalid && I_BREADY) begin
            next_bvalid = 1'b0;
        end
        if (resume_hit) begin
            next_wake_seen = 1'b1;
            next_wake_irq = 1'b1;
            next_usb_clk_en = 1'b1;
            ev[`UWP_IRQ_WAKE] = 1'b1;
        end else if (I_STOP_MODE && !wake_seen) begin
            next_usb_clk_en = 1'b0;
        end else if (!I_STOP_MODE) begin
            next_usb_clk_en = 1'b1;
        end
        // disable clears status
        // after the set: a resume in the disabling cycle must not leave status stuck
        if (!next_wake_en) begin
            next_wake_seen = 1'b0;
            next_wake_irq = 1'b0;
        end
        // set wins over clear
        next_irq_stat = next_irq_stat | ev;
    end

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            wake_en <= 1'b0;
            clk_gate <= 1'b0;
            phy3 <= `UWP_PHY3_RESET;
            irq_mask <= '0;
            irq_stat <= '0;
            usb_clk_en <= 1'b1;
            wake_seen <= 1'b0;
            wake_irq <= 1'b0;
            srst_cnt <= 4'h0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            wake_en <= next_wake_en;
            clk_gate <= next_clk_gate;
            phy3 <= next_phy3;
            irq_mask <= next_irq_mask;
            irq_stat <= next_irq_stat;
            usb_clk_en <= next_usb_clk_en;
            wake_seen <= next_wake_seen;
            wake_irq <= next_wake_irq;
            srst_cnt <= next_srst_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel
    uwp_pkg::uwp_rd_e rd_st, next_rd_st;
    logic [31:0] rdata, next_rdata;
    always_comb begin
        next_rd_st = rd_st;
        next_rdata = rdata;
        unique case (rd_st)
            uwp_pkg::UWP_RD_IDLE: begin
                if (I_ARVALID) begin
                    next_rd_st = uwp_pkg::UWP_RD_RESP;
                    next_rdata = 32'h0;
                    unique case ({I_ARADDR[11:2], 2'b00})
                        `UWP_OFS_WAKE_CTRL: next_rdata = {24'h0, 2'b00, wake_en, clk_gate, 2'b00, combined, wake_seen};
                        `UWP_OFS_PHY_CTRL3: next_rdata = {24'h0, phy3};
                        `UWP_OFS_IRQ_STAT: next_rdata = {30'h0, irq_stat};
                        `UWP_OFS_IRQ_MASK: next_rdata = {30'h0, irq_mask};
                        default: next_rdata = 32'h0;
                    endcase
                end
            end
            uwp_pkg::UWP_RD_RESP: begin
                if (I_RREADY) begin
                    next_rd_st = uwp_pkg::UWP_RD_IDLE;
                end
            end
            default: next_rd_st = uwp_pkg::UWP_RD_IDLE;
        endcase
    end
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rd_st <= uwp_pkg::UWP_RD_IDLE;
            rdata <= 32'h0;
        end else begin
            rd_st <= next_rd_st;
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs
    logic irq_q, srst_q, sel_q;
    logic [4:0] phy_q;
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
            srst_q <= 1'b0;
            sel_q <= 1'b0;
            phy_q <= 5'h0;
        end else begin
            irq_q <= |(next_irq_stat & next_irq_mask);
            srst_q <= (next_srst_cnt != 4'h0);
            sel_q <= next_phy3[`UWP_BIT_SIE_CLK_SEL];
            phy_q <= {next_phy3[`UWP_BIT_PHY_OUTPUT_EN], next_phy3[`UWP_BIT_PHY_POWER_DOWN],
                      next_phy3[`UWP_BIT_PHY_SLEEP], next_phy3[`UWP_BIT_PHY_SLEEP_SEL],
                      next_phy3[`UWP_BIT_SIE_CLK_SEL]};
        end
    end
    assign O_AWREADY = !aw_held;
    assign O_WREADY = !w_held;
    assign O_BVALID = bvalid;
    assign O_BRESP = 2'b00;
    assign O_ARREADY = (rd_st == uwp_pkg::UWP_RD_IDLE);
    assign O_RVALID = (rd_st == uwp_pkg::UWP_RD_RESP);
    assign O_RDATA = rdata;
    assign O_RRESP = 2'b00;
    assign O_USB_SOFT_RST = srst_q;
    assign O_USB_CLK_EN = usb_clk_en;
    assign O_PHY_CLK_GATE = clk_gate;
    assign O_SIE_CLK_SEL_60 = sel_q;
    assign O_PHY_CTRL = phy_q;
    assign O_WAKE_IRQ = wake_irq;
    assign O_IRQ = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    sequence k_with_en_s;
        wake_en && next_wake_en && I_LINE_K && !wake_seen;
    endsequence
    wake_status_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        k_with_en_s |=> wake_seen) else $error("wake status not set");
    wake_irq_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        k_with_en_s |=> O_WAKE_IRQ) else $error("wake irq missing");
    clock_restore_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        k_with_en_s |=> O_USB_CLK_EN) else $error("usb clocks not restored");
    combined_flag_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        (rd_st == uwp_pkg::UWP_RD_IDLE && I_ARVALID && I_ARADDR == `UWP_OFS_WAKE_CTRL)
        |=> O_RDATA[`UWP_BIT_COMBINED_IRQ] == $past(combined)) else $error("combined flag wrong");
    seen_clear_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        !wake_en |-> !wake_seen) else $error("wake status survives disable");
    seen_hold_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        wake_seen && wake_en && $stable(wake_en) |-> $past(wake_seen) || $past(resume_hit))
        else $error("wake status set without cause");
    clk_sel_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        O_SIE_CLK_SEL_60 == phy3[`UWP_BIT_SIE_CLK_SEL]) else $error("sie clock select wrong");
    sel_one_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        phy3[`UWP_BIT_SIE_CLK_SEL] |-> O_SIE_CLK_SEL_60) else $error("60 mhz not selected");
    resp_okay_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        O_BVALID |-> O_BRESP == 2'b00) else $error("write error answered");
    srst_pulse_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        (do_wr && aw_addr[11:2] == 10'h040 && w_strb[0] && w_data[`UWP_BIT_SOFT_RESET])
        |=> O_USB_SOFT_RST [*4] ##1 !O_USB_SOFT_RST) else $error("soft reset pulse wrong");
    trig_zero_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        (rd_st == uwp_pkg::UWP_RD_IDLE && I_ARVALID && I_ARADDR[11:2] == 10'h040)
        |=> !O_RDATA[`UWP_BIT_SOFT_RESET]) else $error("trigger reads nonzero");
endmodule // uwp_wake_ctrl
`default_nettype wire

// [hw/uwp_consts.svh]
// register offsets, field positions and reset values of the wake and phy control block
`ifndef UWP_CONSTS_SVH
`define UWP_CONSTS_SVH
`define UWP_OFS_WAKE_CTRL 12'h100
`define UWP_OFS_PHY_CTRL3 12'h118
`define UWP_OFS_IRQ_STAT 12'h120
`define UWP_OFS_IRQ_MASK 12'h124
`define UWP_OFS_IRQ_EVENTS 12'h128
`define UWP_OFS_IRQ_ENABLES 12'h12c
`define UWP_BIT_WAKE_SEEN 0
`define UWP_BIT_COMBINED_IRQ 1
`define UWP_BIT_PHY_CLK_GATE 4
`define UWP_BIT_WAKE_EN 5
`define UWP_BIT_SOFT_RESET 7
`define UWP_PHY3_MASK 8'hff
`define UWP_PHY3_RESET 8'h08
`define UWP_BIT_SIE_CLK_SEL 0
`define UWP_BIT_PHY_SLEEP_SEL 1
`define UWP_BIT_PHY_SLEEP 2
`define UWP_BIT_PHY_POWER_DOWN 3
`define UWP_BIT_PHY_OUTPUT_EN 6
`define UWP_IRQ_WAKE 0
`define UWP_IRQ_SOFT_RESET 1
`define UWP_IRQ_BITS 2
`define UWP_SOFT_RESET_CYCLES 4'h4
`endif

// [hw/uwp_pkg.sv]
// types of the wake and phy control block
`default_nettype none
package uwp_pkg;
    typedef enum logic [1:0] {
        UWP_RD_IDLE = 2'b00,
        UWP_RD_RESP = 2'b01
    } uwp_rd_e;
    typedef struct packed {
        logic wake_seen;
        logic usb_clk_on;
        logic wake_irq;
    } uwp_wake_s;
    typedef struct packed {
        logic sie_clk_sel;
        logic phy_sleep_sel;
        logic phy_sleep;
        logic phy_power_down;
        logic phy_output_enable;
    } uwp_phy_s;
endpackage : uwp_pkg
`default_nettype wire

// [dv/uwp_host_model.sv]
// usb host model that drives resume k-state onto the device's line
`default_nettype none
module uwp_host_model (
    // clock
    input wire logic i_clk,
    // resume request from the bench
    input wire logic i_go,
    input wire logic [3:0] i_len,
    // line state towards the device
    output logic o_line_k
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] left = 4'h0;
    ////////////////////////////////////////////////////////////////
    // idle is j: k stays low between resumes once the length counter reaches zero
    always @(posedge i_clk) begin
        if (i_go) begin
            left <= i_len;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
        end
    end
    assign o_line_k = (left != 4'h0);
endmodule // uwp_host_model
`default_nettype wire

// [dv/tb.sv]
// self-checking bench of the wake and phy control block
`include "uwp_consts.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, arst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, stop = 1'b0, go = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, d;
    logic [3:0] wstrb = 4'hf, klen = 4'h1;
    logic [7:0] istat = 8'h00, ienb = 8'h00;
    logic awready, wready, bvalid, arready, rvalid, srst, clken, gate, sel60, wirq, irq, line_k;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [4:0] phy;
    logic [31:0] expq[$];
    int err_count = 0, n_tests = 0, nrst = 0;
    always #20 clk = ~clk;
    always @(posedge clk) if (srst === 1'b1) nrst <= nrst + 1;
    uwp_wake_ctrl DUT (.I_CLK(clk), .I_ARST_N(arst_n),
        .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
        .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
        .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
        .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
        .I_RREADY(rready), .I_LINE_K(line_k), .I_STOP_MODE(stop), .I_USB_INT_STAT(istat),
        .I_USB_INTERRUPT_ENABLE_BITS(ienb), .O_USB_SOFT_RST(srst), .O_USB_CLK_EN(clken),
        .O_PHY_CLK_GATE(gate), .O_SIE_CLK_SEL_60(sel60), .O_PHY_CTRL(phy),
        .O_WAKE_IRQ(wirq), .O_IRQ(irq));
    uwp_host_model host (.i_clk(clk), .i_go(go), .i_len(klen), .o_line_k(line_k));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // master holds each channel until its own ready is sampled
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic aws, ws, bs;
        logic [1:0] r;
        bs = 1'b0;
        r = 2'b11;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int t = 0; t < 50 && !bs; t++) begin
            @(negedge clk);
            aws = awready;
            ws = wready;
            bs = bvalid;
            r = bresp;
            @(posedge clk);
            awvalid <= awvalid & ~aws;
            wvalid <= wvalid & ~ws;
            bready <= ~bs;
        end
        chk("bresp", {29'h0, ~bs, r}, 32'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic ars, rs;
        rs = 1'b0;
        expq.push_back(e);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int t = 0; t < 50 && !rs; t++) begin
            @(negedge clk);
            ars = arready;
            rs = rvalid;
            @(posedge clk);
            arvalid <= arvalid & ~ars;
            rready <= ~rs;
        end
        chk("rd_done", {31'h0, rs}, 32'h1);
    endtask
    task automatic pulse(input logic [3:0] n);
        @(posedge clk);
        klen <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // read data checked against the oldest noted value
    always @(negedge clk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            chk("rdata", rdata, expq.pop_front());
            chk("rresp", {30'h0, rresp}, 32'h0);
        end
    end
    initial begin
        #(40 * 6000);
        err_count++;
        results();
    end
    initial begin
        void'($urandom(32'he484));
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        cyc(4);
        chk("clk_en", clken, 32'h1);
        chk("phy_rst", phy, 5'b01000);
        rd(`UWP_OFS_WAKE_CTRL, 32'h0);
        rd(`UWP_OFS_PHY_CTRL3, 32'h8);
        rd(12'h200, 32'h0);
        wr(12'h204, 32'hffffffff);
        for (int i = 0; i < 6; i++) begin
            d = $urandom();
            d[0] = i[0];
            wr(`UWP_OFS_PHY_CTRL3, d);
            cyc(1);
            chk("sel60", sel60, d[0]);
            chk("phy", phy, {d[6], d[3:0]});
            rd(`UWP_OFS_PHY_CTRL3, {24'h0, d[7:0]});
        end
        wr(`UWP_OFS_WAKE_CTRL, 32'hffffff5f);
        cyc(1);
        chk("gate", gate, 32'h1);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            istat <= 8'($urandom());
            ienb <= (i == 0) ? 8'h00 : 8'($urandom());
            cyc(2);
            rd(`UWP_OFS_WAKE_CTRL, {30'h4, |(istat & ienb), 1'b0});
        end
        @(posedge clk);
        istat <= 8'h00;
        stop <= 1'b1;
        cyc(4);
        chk("clk_off", clken, 32'h0);
        pulse(4'h1);
        cyc(4);
        chk("wake_off", wirq, 32'h0);
        wr(`UWP_OFS_IRQ_MASK, 32'h1);
        wr(`UWP_OFS_WAKE_CTRL, 32'h30);
        pulse(4'h8);
        for (int t = 0; t < 20 && wirq !== 1'b1; t++) cyc(1);
        cyc(1);
        chk("wake_irq", wirq, 32'h1);
        chk("clk_on", clken, 32'h1);
        chk("irq", irq, 32'h1);
        rd(`UWP_OFS_WAKE_CTRL, 32'h31);
        stop <= 1'b0;
        wr(`UWP_OFS_IRQ_STAT, 32'h1);
        cyc(1);
        chk("irq_clr", irq, 32'h0);
        rd(`UWP_OFS_WAKE_CTRL, 32'h31);
        wr(`UWP_OFS_WAKE_CTRL, 32'h10);
        cyc(1);
        chk("wake_clr", wirq, 32'h0);
        rd(`UWP_OFS_WAKE_CTRL, 32'h10);
        d = nrst;
        wr(`UWP_OFS_WAKE_CTRL, 32'h80);
        cyc(8);
        chk("srst_len", nrst - d, `UWP_SOFT_RESET_CYCLES);
        rd(`UWP_OFS_WAKE_CTRL, 32'h0);
        rd(`UWP_OFS_IRQ_STAT, 32'h2);
        chk("irq_masked", irq, 32'h0);
        wr(`UWP_OFS_IRQ_MASK, 32'h3);
        cyc(1);
        chk("irq_set", irq, 32'h1);
        wr(`UWP_OFS_IRQ_STAT, 32'h2);
        cyc(1);
        chk("irq_w1c", irq, 32'h0);
        results();
    end
endmodule // tb
`default_nettype wire
